/* include/irq_defines.svh */
// Offsets, bit positions and reset values of the pin interrupt block.
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_FLAGS 8'h04
`define OFS_MASK_HIGH 8'h08
`define OFS_MASK_LOW 8'h0C
`define OFS_SENSE 8'h10
`define OFS_MODE 8'h14

// ----------------------------------------------------------------------
// Bit positions shared by control and flag registers
// ----------------------------------------------------------------------
`define BIT_EXT1 7
`define BIT_EXT0 6
`define BIT_EXT2 5
`define BIT_GROUP1 4
`define BIT_GROUP0 3

// ----------------------------------------------------------------------
// Sense and mode register fields
// ----------------------------------------------------------------------
`define SENSE_EXT1_HI 3
`define SENSE_EXT1_LO 2
`define SENSE_EXT0_HI 1
`define SENSE_EXT0_LO 0
`define SENSE_EXT2_EDGE 4
`define MODE_LEGACY 0

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define CONTROL_MASK 8'hF8
`define SENSE_MASK 8'h1F
`define MODE_MASK 8'h01
`define WORD_PAD 24'h000000

`endif

/* include/irq_pkg.sv */
// Types shared by the pin interrupt block and its sub-modules.
package irq_pkg;

    // ------------------------------------------------------------------
    // One bit per interrupt source, in flag register order
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ext1;
        logic ext0;
        logic ext2;
        logic group1;
        logic group0;
    } irq_vec_t;

    // ------------------------------------------------------------------
    // Request condition of an external pin, in two-bit code order
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_ANY,
        SENSE_FALL,
        SENSE_RISE
    } sense_mode_t;

endpackage : irq_pkg

/* rtl/ext_sense.sv */
// Edge and level sensing for one external interrupt pin.
`timescale 1ns/10ps
module ext_sense (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire irq_pkg::sense_mode_t sense_i,
    output logic event_o,
    output logic low_level_o
);

    logic sample;
    logic prev;
    logic primed;
    logic rose;
    logic fell;

    // The pin is sampled once before edges are looked for.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample <= 1'b0;
            prev <= 1'b0;
            primed <= 1'b0;
        end else begin
            sample <= pin_i;
            prev <= primed ? sample : pin_i;
            primed <= 1'b1;
        end
    end

    function automatic logic detect(irq_pkg::sense_mode_t m, logic r,
                                    logic f);
        case (m)
            irq_pkg::SENSE_ANY: detect = r | f;
            irq_pkg::SENSE_FALL: detect = f;
            irq_pkg::SENSE_RISE: detect = r;
            default: detect = 1'b0;
        endcase
    endfunction : detect

    // The first sample after reset is no edge.
    assign rose = primed & sample & ~prev;
    assign fell = primed & ~sample & prev;
    assign event_o = detect(sense_i, rose, fell);
    assign low_level_o = (sense_i == irq_pkg::SENSE_LOW) & ~sample;

endmodule : ext_sense

/* rtl/change_detect.sv */
// Change detection for one group of eight pin-change inputs.
`timescale 1ns/10ps
`include "irq_defines.svh"
module change_detect (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] pins_i,
    input wire logic [7:0] mask_i,
    input wire logic enable_i,
    output logic change_o
);

    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic primed;

    // Two stages guard against metastable pins; prev holds the last sample.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= `RESET_BYTE;
            sync2 <= `RESET_BYTE;
            prev <= `RESET_BYTE;
            primed <= 1'b0;
        end else begin
            sync1 <= pins_i;
            sync2 <= sync1;
            prev <= sync2;
            primed <= 1'b1;
        end
    end

    // Only masked-in pins of an enabled group count.
    assign change_o = enable_i & primed & |((sync2 ^ prev) & mask_i);

endmodule : change_detect

/* rtl/ext_and_pin_change_irq.sv */
// External pin and pin-change interrupt logic with a Wishbone slave.
//
// Functional notes
// - Group 1 changes request when enabled globally.
// - Group 0 changes request when enabled globally.
// - Each group has its own request line.
// - External 1 event sets flag bit 7.
// - External 0 event sets flag bit 6.
// - External 2 event sets flag bit 5.
// - Group changes set flag bits 4 and 3.
// - Set, enabled flag with global enable requests.
// - Flags clear on vector entry or write-one.
// - Level-sensed external 1/0 flags read zero.
// - Sleep buffer shutoff may set external 2 flag.
// - High mask bits gate group 1 pins.
// - Low mask bits gate group 0 pins.
// - Mask registers read/write, reset to zero.
// - Legacy mode disables pin-change function.
// - Two-bit sense: low, change, fall, rise.
// - External 2 edge select: fall or rise.
// - Pin activity requests regardless of direction.
`timescale 1ns/10ps
`include "irq_defines.svh"
module ext_and_pin_change_irq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic gie_i,
    input wire logic sleep_i,
    input wire logic ext1_pin_i,
    input wire logic ext0_pin_i,
    input wire logic ext2_pin_i,
    input wire logic [7:0] change_pins_high_i,
    input wire logic [7:0] change_pins_low_i,
    input wire irq_pkg::irq_vec_t vector_taken_i,
    output irq_pkg::irq_vec_t irq_request_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    function automatic logic [7:0] vec_to_byte(irq_pkg::irq_vec_t v);
        logic [7:0] b;
        b = `RESET_BYTE;
        b[`BIT_EXT1] = v.ext1;
        b[`BIT_EXT0] = v.ext0;
        b[`BIT_EXT2] = v.ext2;
        b[`BIT_GROUP1] = v.group1;
        b[`BIT_GROUP0] = v.group0;
        vec_to_byte = b;
    endfunction : vec_to_byte

    function automatic irq_pkg::irq_vec_t byte_to_vec(logic [7:0] b);
        irq_pkg::irq_vec_t v;
        v.ext1 = b[`BIT_EXT1];
        v.ext0 = b[`BIT_EXT0];
        v.ext2 = b[`BIT_EXT2];
        v.group1 = b[`BIT_GROUP1];
        v.group0 = b[`BIT_GROUP0];
        byte_to_vec = v;
    endfunction : byte_to_vec

    // A set in the same cycle as a clear wins, so no event is lost.
    function automatic logic flag_next(logic cur, logic set, logic clr,
                                       logic force_zero);
        if (force_zero) begin
            flag_next = 1'b0;
        end else begin
            flag_next = set | (cur & ~clr);
        end
    endfunction : flag_next

    // ------------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------------

    logic [7:0] irq_control;
    logic [7:0] change_mask_high;
    logic [7:0] change_mask_low;
    logic [7:0] sense_config;
    logic [7:0] mode_config;
    irq_pkg::irq_vec_t irq_flags;
    irq_pkg::irq_vec_t next_flags;
    irq_pkg::irq_vec_t next_request;
    irq_pkg::irq_vec_t enables;
    irq_pkg::irq_vec_t set_events;
    irq_pkg::irq_vec_t write_clear;
    irq_pkg::irq_vec_t clear_events;

    // ------------------------------------------------------------------
    // Wishbone slave decode
    // ------------------------------------------------------------------

    logic take;
    logic wr_fire;
    logic hit_control;
    logic hit_flags;
    logic hit_mask_high;
    logic hit_mask_low;
    logic hit_sense;
    logic hit_mode;
    logic [7:0] wr_byte;
    logic [7:0] read_byte;

    // Ack follows one cycle after the request; writes land on the ack
    // edge, which is the only edge the master treats as the transfer.
    assign take = cyc_i & stb_i & ~ack_o;
    assign wr_fire = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign wr_byte = dat_i[7:0];
    assign hit_control = (adr_i == `OFS_CONTROL);
    assign hit_flags = (adr_i == `OFS_FLAGS);
    assign hit_mask_high = (adr_i == `OFS_MASK_HIGH);
    assign hit_mask_low = (adr_i == `OFS_MASK_LOW);
    assign hit_sense = (adr_i == `OFS_SENSE);
    assign hit_mode = (adr_i == `OFS_MODE);

    // Unmapped addresses are acknowledged and read as zero.
    assign read_byte = hit_control ? irq_control :
                       hit_flags ? vec_to_byte(irq_flags) :
                       hit_mask_high ? change_mask_high :
                       hit_mask_low ? change_mask_low :
                       hit_sense ? sense_config :
                       hit_mode ? mode_config :
                       `RESET_BYTE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= {`WORD_PAD, `RESET_BYTE};
        end else if (take) begin
            dat_o <= {`WORD_PAD, read_byte};
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_control <= `RESET_BYTE;
        end else if (wr_fire & hit_control) begin
            irq_control <= wr_byte & `CONTROL_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_mask_high <= `RESET_BYTE;
        end else if (wr_fire & hit_mask_high) begin
            change_mask_high <= wr_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_mask_low <= `RESET_BYTE;
        end else if (wr_fire & hit_mask_low) begin
            change_mask_low <= wr_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_config <= `RESET_BYTE;
        end else if (wr_fire & hit_sense) begin
            sense_config <= wr_byte & `SENSE_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_config <= `RESET_BYTE;
        end else if (wr_fire & hit_mode) begin
            mode_config <= wr_byte & `MODE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------

    irq_pkg::sense_mode_t ext1_mode;
    irq_pkg::sense_mode_t ext0_mode;
    irq_pkg::sense_mode_t ext2_mode;
    logic legacy;
    logic ext1_level;
    logic ext0_level;
    logic ext2_buffer_off;
    logic ext2_internal;
    logic group1_active;
    logic group0_active;

    assign enables = byte_to_vec(irq_control);
    assign ext1_mode = irq_pkg::sense_mode_t'({
        sense_config[`SENSE_EXT1_HI], sense_config[`SENSE_EXT1_LO]});
    assign ext0_mode = irq_pkg::sense_mode_t'({
        sense_config[`SENSE_EXT0_HI], sense_config[`SENSE_EXT0_LO]});
    // External 2 only has the two edge codes of the shared decoder.
    assign ext2_mode = irq_pkg::sense_mode_t'({
        1'b1, sense_config[`SENSE_EXT2_EDGE]});
    assign ext1_level = (ext1_mode == irq_pkg::SENSE_LOW);
    assign ext0_level = (ext0_mode == irq_pkg::SENSE_LOW);
    assign legacy = mode_config[`MODE_LEGACY];

    // In sleep with external 2 disabled the input buffer is shut off and
    // the internal level drops; the edge this makes may set the flag.
    assign ext2_buffer_off = sleep_i & ~enables.ext2;
    assign ext2_internal = ext2_buffer_off ? 1'b0 : ext2_pin_i;

    // The mask registers stay writable in legacy mode, but both group
    // enables are gated there, so the whole pin-change function is switched off.
    assign group1_active = enables.group1 & ~legacy;
    assign group0_active = enables.group0 & ~legacy;

    // ------------------------------------------------------------------
    // Pin sensing
    // ------------------------------------------------------------------

    logic ext1_event;
    logic ext0_event;
    logic ext2_event;
    logic ext1_low;
    logic ext0_low;
    logic ext2_low_unused;
    logic group1_change;
    logic group0_change;

    // Pins are sensed whatever their port direction is.
    ext_sense ext1_sense (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext1_pin_i),
        .sense_i(ext1_mode),
        .event_o(ext1_event),
        .low_level_o(ext1_low)
    );

    ext_sense ext0_sense (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext0_pin_i),
        .sense_i(ext0_mode),
        .event_o(ext0_event),
        .low_level_o(ext0_low)
    );

    ext_sense ext2_sense (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext2_internal),
        .sense_i(ext2_mode),
        .event_o(ext2_event),
        .low_level_o(ext2_low_unused)
    );

    change_detect group1_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i(change_pins_high_i),
        .mask_i(change_mask_high),
        .enable_i(group1_active),
        .change_o(group1_change)
    );

    change_detect group0_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i(change_pins_low_i),
        .mask_i(change_mask_low),
        .enable_i(group0_active),
        .change_o(group0_change)
    );

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------

    assign set_events.ext1 = ext1_event;
    assign set_events.ext0 = ext0_event;
    assign set_events.ext2 = ext2_event;
    assign set_events.group1 = group1_change;
    assign set_events.group0 = group0_change;

    assign write_clear = byte_to_vec((wr_fire & hit_flags) ?
                                     wr_byte : `RESET_BYTE);
    assign clear_events = write_clear | vector_taken_i;

    // Level-sensed pins keep no flag; their request follows the pin.
    assign next_flags.ext1 = flag_next(irq_flags.ext1, set_events.ext1,
                                       clear_events.ext1, ext1_level);
    assign next_flags.ext0 = flag_next(irq_flags.ext0, set_events.ext0,
                                       clear_events.ext0, ext0_level);
    assign next_flags.ext2 = flag_next(irq_flags.ext2, set_events.ext2,
                                       clear_events.ext2, 1'b0);
    assign next_flags.group1 = flag_next(irq_flags.group1,
                                         set_events.group1,
                                         clear_events.group1, 1'b0);
    assign next_flags.group0 = flag_next(irq_flags.group0,
                                         set_events.group0,
                                         clear_events.group0, 1'b0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_flags <= byte_to_vec(`RESET_BYTE);
        end else begin
            irq_flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Requests towards the CPU vectoring
    // ------------------------------------------------------------------

    // Each source drives its own line so the CPU picks its own vector.
    assign next_request.ext1 = gie_i & enables.ext1 &
                               (ext1_level ? ext1_low : irq_flags.ext1);
    assign next_request.ext0 = gie_i & enables.ext0 &
                               (ext0_level ? ext0_low : irq_flags.ext0);
    assign next_request.ext2 = gie_i & enables.ext2 & irq_flags.ext2;
    assign next_request.group1 = gie_i & group1_active &
                                 irq_flags.group1;
    assign next_request.group0 = gie_i & group0_active &
                                 irq_flags.group0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_request_o <= byte_to_vec(`RESET_BYTE);
        end else begin
            irq_request_o <= next_request;
        end
    end

endmodule : ext_and_pin_change_irq

/* testbench/cpu_vector_model.sv */
// Model of the CPU vectoring logic that takes pending requests.
`timescale 1ns/10ps
module cpu_vector_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [3:0] delay_i,
    input wire irq_pkg::irq_vec_t request_i,
    output irq_pkg::irq_vec_t taken_o
);
    logic [4:0] wait_cnt;
    logic [4:0] req_bits;
    logic [4:0] pick;
    logic fire;

    assign req_bits = request_i;
    assign pick = req_bits & (~req_bits + 5'h01);
    assign fire = enable_i && !rst_i && req_bits != 5'h00
        && wait_cnt == {1'b0, delay_i};
    // Driven from registers and levels only, so the pulse lasts one cycle.
    assign taken_o = fire ? irq_pkg::irq_vec_t'(pick) : '0;

    // The request falls two edges after a pulse; the extra three counts
    // keep the model from taking the same source twice.
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i || req_bits == 5'h00)
            wait_cnt <= 5'h00;
        else if (wait_cnt == {1'b0, delay_i} + 5'h03)
            wait_cnt <= 5'h00;
        else
            wait_cnt <= wait_cnt + 5'h01;
    end
endmodule : cpu_vector_model

/* testbench/irq_port_assertions.sv */
// Port-level assertions for the pin interrupt block.
`timescale 1ns/10ps
module irq_port_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic gie_i,
    input wire logic sleep_i,
    input wire logic ext1_pin_i,
    input wire logic ext0_pin_i,
    input wire logic ext2_pin_i,
    input wire logic [7:0] change_pins_high_i,
    input wire logic [7:0] change_pins_low_i,
    input wire irq_pkg::irq_vec_t vector_taken_i,
    input wire irq_pkg::irq_vec_t irq_request_o
);
    logic [2:0] quiet_high;
    logic [2:0] quiet_low;

    // A clear is only judged when no pin change can reach the flag at the
    // same edge, since a simultaneous set must win.
    always_ff @(posedge clk_i) begin
        if (rst_i || $changed(change_pins_high_i))
            quiet_high <= 3'h0;
        else if (quiet_high != 3'h7)
            quiet_high <= quiet_high + 3'h1;
        if (rst_i || $changed(change_pins_low_i))
            quiet_low <= 3'h0;
        else if (quiet_low != 3'h7)
            quiet_low <= quiet_low + 3'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_once;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack is not one pulse after a request");
    property p_ack_cause;
        !(cyc_i && stb_i) |=> !ack_o;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without a request");
    property p_dat_pad;
        ack_o |-> dat_o[31:8] == 24'h000000;
    endproperty
    a_dat_pad: assert property (p_dat_pad)
        else $error("read data upper bytes not zero");
    property p_dat_hold;
        !(cyc_i && stb_i && !ack_o) |=> $stable(dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold)
        else $error("read data moved without an access");
    property p_reset_quiet;
        $fell(rst_i) |-> irq_request_o == 5'h00 && !ack_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("requests or ack active after reset");
    property p_gie_off;
        !gie_i |=> irq_request_o == 5'h00;
    endproperty
    a_gie_off: assert property (p_gie_off)
        else $error("request while global enable is off");
    property p_req_gie;
        irq_request_o != 5'h00 |-> $past(gie_i);
    endproperty
    a_req_gie: assert property (p_req_gie)
        else $error("request without prior global enable");
    property p_clear_high;
        vector_taken_i.group1 && quiet_high >= 3'h4
            && $stable(change_pins_high_i) |-> ##2 !irq_request_o.group1;
    endproperty
    a_clear_high: assert property (p_clear_high)
        else $error("group1 request stays after vector entry");
    property p_clear_low;
        vector_taken_i.group0 && quiet_low >= 3'h4
            && $stable(change_pins_low_i) |-> ##2 !irq_request_o.group0;
    endproperty
    a_clear_low: assert property (p_clear_low)
        else $error("group0 request stays after vector entry");

    c_write: cover property (cyc_i && stb_i && we_i && ack_o);
    c_group1: cover property ($rose(irq_request_o.group1));
    c_ext1: cover property ($rose(irq_request_o.ext1));
endmodule : irq_port_checker

bind ext_and_pin_change_irq irq_port_checker u_checker (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .gie_i, .sleep_i, .ext1_pin_i, .ext0_pin_i, .ext2_pin_i,
    .change_pins_high_i, .change_pins_low_i, .vector_taken_i,
    .irq_request_o);

/* testbench/tb.sv */
// Self-checking bench for the pin interrupt block.
`timescale 1ns/10ps
`include "irq_defines.svh"
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic gie_i = 1'b0;
    logic sleep_i = 1'b0;
    logic ext1_pin_i = 1'b1;
    logic ext0_pin_i = 1'b1;
    logic ext2_pin_i = 1'b1;
    logic [7:0] change_pins_high_i = 8'h00;
    logic [7:0] change_pins_low_i = 8'h00;
    irq_pkg::irq_vec_t vector_taken_i;
    irq_pkg::irq_vec_t irq_request_o;
    logic vec_en = 1'b0;
    logic [3:0] vec_delay = 4'h0;
    logic [7:0] irq_bits;
    logic [7:0] junk;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] ofs [7] = '{`OFS_CONTROL, `OFS_FLAGS, `OFS_MASK_HIGH,
        `OFS_MASK_LOW, `OFS_SENSE, `OFS_MODE, 8'h18};

    assign irq_bits = {irq_request_o, 3'b000};
    always #2 clk_i = ~clk_i;

    ext_and_pin_change_irq u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .gie_i, .sleep_i,
        .ext1_pin_i, .ext0_pin_i, .ext2_pin_i, .change_pins_high_i,
        .change_pins_low_i, .vector_taken_i, .irq_request_o);
    cpu_vector_model u_cpu (.clk_i, .rst_i, .enable_i(vec_en),
        .delay_i(vec_delay), .request_i(irq_request_o),
        .taken_o(vector_taken_i));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic check(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Entered in the time step of a rising edge; the request stays up
    // until the edge at which ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF, junk);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a,
            input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 4'hF, q);
        check(what, exp, q);
    endtask : rd

    task automatic probe(input int idx, input logic lvl, input logic fl,
            input logic rq);
        if (idx == `BIT_EXT1) ext1_pin_i <= lvl;
        else if (idx == `BIT_EXT0) ext0_pin_i <= lvl;
        else ext2_pin_i <= lvl;
        tick(5);
        check("pin request", {7'h00, rq}, {7'h00, irq_bits[idx]});
        rd("pin flag", `OFS_FLAGS, fl ? 8'h01 << idx : 8'h00);
        wr(`OFS_FLAGS, 8'hFF);
    endtask : probe

    initial begin
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        foreach (ofs[i]) rd("reset value", ofs[i], 8'h00);
        wr(`OFS_MASK_HIGH, 8'hA5);
        wr(`OFS_MASK_LOW, 8'h5A);
        bus(1'b1, `OFS_MASK_HIGH, 8'hFF, 4'hE, junk);
        wr(8'h18, 8'hFF);
        rd("mask high", `OFS_MASK_HIGH, 8'hA5);
        rd("mask low", `OFS_MASK_LOW, 8'h5A);
        rd("unmapped", 8'h18, 8'h00);
        wr(`OFS_CONTROL, 8'hFF);
        rd("control", `OFS_CONTROL, 8'hF8);
        wr(`OFS_CONTROL, 8'hE0);
        gie_i <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_SENSE, {4'h0, m[1:0], m[1:0]});
            for (int i = 6; i < 8; i++) begin
                probe(i, 1'b0, m == 1 || m == 2, m != 3);
                probe(i, 1'b1, m == 1 || m == 3, m[0]);
            end
        end
        for (int e = 0; e < 2; e++) begin
            wr(`OFS_SENSE, {3'h0, e[0], 4'h0});
            probe(5, 1'b0, e == 0, e == 0);
            probe(5, 1'b1, e == 1, e == 1);
        end
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_SENSE, 8'h00);
        sleep_i <= 1'b1;
        tick(5);
        rd("sleep flag", `OFS_FLAGS, 8'h20);
        sleep_i <= 1'b0;
        tick(5);
        wr(`OFS_FLAGS, 8'hFF);
        wr(`OFS_MASK_HIGH, 8'h01);
        wr(`OFS_MASK_LOW, 8'h80);
        wr(`OFS_CONTROL, 8'h18);
        change_pins_high_i <= 8'h02;
        change_pins_low_i <= 8'h7F;
        tick(6);
        rd("masked pins", `OFS_FLAGS, 8'h00);
        change_pins_high_i <= 8'h03;
        tick(6);
        check("group1 request", 8'h10, irq_bits);
        rd("group1 flag", `OFS_FLAGS, 8'h10);
        wr(`OFS_FLAGS, 8'h10);
        change_pins_low_i <= 8'hFF;
        tick(6);
        check("group0 request", 8'h08, irq_bits);
        rd("group0 flag", `OFS_FLAGS, 8'h08);
        wr(`OFS_FLAGS, 8'h08);
        tick(3);
        check("cleared requests", 8'h00, irq_bits);
        wr(`OFS_CONTROL, 8'h00);
        change_pins_high_i <= 8'h02;
        tick(6);
        wr(`OFS_CONTROL, 8'h18);
        rd("group off", `OFS_FLAGS, 8'h00);
        wr(`OFS_MODE, 8'h01);
        change_pins_high_i <= 8'h03;
        tick(6);
        rd("legacy flag", `OFS_FLAGS, 8'h00);
        check("legacy request", 8'h00, irq_bits);
        wr(`OFS_MODE, 8'h00);
        tick(6);
        change_pins_high_i <= 8'h02;
        tick(1);
        wr(`OFS_FLAGS, 8'h10);
        rd("set wins", `OFS_FLAGS, 8'h10);
        wr(`OFS_FLAGS, 8'h10);
        for (int k = 0; k < 2; k++) begin
            gie_i <= 1'b0;
            vec_delay <= k ? 4'h5 : 4'h0;
            if (k) change_pins_high_i <= change_pins_high_i ^ 8'h01;
            else change_pins_low_i <= change_pins_low_i ^ 8'h80;
            tick(6);
            check("gated request", 8'h00, irq_bits);
            gie_i <= 1'b1;
            tick(2);
            check("open request", k ? 8'h10 : 8'h08, irq_bits);
            vec_en <= 1'b1;
            tick(12);
            check("vectored request", 8'h00, irq_bits);
            rd("vectored flag", `OFS_FLAGS, 8'h00);
            vec_en <= 1'b0;
        end
        give_verdict();
    end
endmodule : tb
